//--- hdl/bps_sequencer.sv
`timescale 1ns/1ps
`include "bps_regs.svh"
module bps_sequencer #(
  parameter logic [21:0] MS_CYC = 22'(`BPS_T_MS_NS / `BPS_CLK_NS),
  parameter logic [21:0] BOOT_CYC = 22'(`BPS_T_BOOT_NS / `BPS_CLK_NS),
  parameter logic [21:0] WD_CYC = 22'(`BPS_T_WD_NS / `BPS_CLK_NS),
  parameter logic [21:0] RETRY_CYC = 22'(`BPS_T_RETRY_NS / `BPS_CLK_NS)
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire bps_pkg::bps_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic master_en,
  input wire logic [2:0] en_pin,
  input wire logic host_alive_pin_n,
  input wire logic ot_fault,
  input wire logic [3:0] oc_det,
  input wire logic [3:0] vout_low,
  input wire logic [3:0] ramp_done,
  output logic bias_on,
  output bps_pkg::bps_out_t [3:0] buck_o,
  output logic [3:0][9:0] target,
  output logic irq_o,
  output logic irq_oe
);
  import bps_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire [1:0] bus_bi = bus_req.addr[5:4];
  wire [3:0] bus_off = bus_req.addr[3:0];
  wire bus_buck = bus_req.addr[7:6] == `BPS_SEL_BUCK;
  wire bus_glob = bus_req.addr[7:6] == `BPS_SEL_GLOB;

  function automatic logic glob_wr(input bps_req_t r, input logic [3:0] o);
    glob_wr = r.wr && r.addr[7:6] == `BPS_SEL_GLOB && r.addr[3:0] == o;
  endfunction : glob_wr

  function automatic logic buck_wr(input bps_req_t r, input logic [1:0] b,
                                   input logic [3:0] o);
    buck_wr = r.wr && r.addr[7:6] == `BPS_SEL_BUCK && r.addr[5:4] == b &&
              r.addr[3:0] == o;
  endfunction : buck_wr

  // ----------------------------------------
  // global state
  // ----------------------------------------
  bps_state_t state_reg, state_next;
  logic auto_reg;
  logic [2:0] pinfn_reg;
  logic [4:0] irqc_reg;
  logic [21:0] boot_reg, div_reg, wd_reg, retry_reg;
  logic [6:0] ms_reg;
  logic bias_reg, irq_o_reg, irq_oe_reg;
  logic [7:0] rdata_reg;
  bps_cfg_t cfg_reg [4];
  logic [1:0] vlow_reg [4];
  logic [3:0][9:0] tgt_reg;
  bps_out_t [3:0] out_reg;
  logic [3:0] oc_reg, ss_reg, wdr_reg, dn_reg, go_reg, run_next;

  wire load = state_reg == BPS_OFF && master_en;
  wire boot_done = boot_reg == BOOT_CYC - 22'h1;
  wire ms_tick = div_reg == MS_CYC - 22'h1;
  wire phase_chg = state_next != state_reg;
  wire wd_fire = state_reg == BPS_RUN && !host_alive_pin_n && wd_reg == WD_CYC - 22'h1;
  wire retry_tick = retry_reg == RETRY_CYC - 22'h1;
  wire all_low = &(vout_low & ~run_next);
  wire [3:0] pin_v = {1'b1, en_pin};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BPS_OFF: if (master_en) state_next = BPS_BOOT;
      BPS_BOOT: begin
        if (!master_en) state_next = BPS_OFF;
        else if (boot_done) state_next = BPS_RUN;
      end
      BPS_RUN: if (!master_en) state_next = BPS_DOWN;
      BPS_DOWN: if (all_low) state_next = BPS_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= BPS_OFF;
      bias_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bias_reg <= state_next != BPS_OFF;
    end
  end

  // ----------------------------------------
  // boot and 1ms timebase
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      boot_reg <= 22'h0;
      div_reg <= 22'h0;
      ms_reg <= 7'h0;
    end else begin
      boot_reg <= state_reg == BPS_BOOT ? boot_reg + 22'h1 : 22'h0;
      if (phase_chg) begin
        div_reg <= 22'h0;
        ms_reg <= 7'h0;
      end else begin
        div_reg <= ms_tick ? 22'h0 : div_reg + 22'h1;
        if (ms_tick && ms_reg != 7'h7f) ms_reg <= ms_reg + 7'h1;
      end
    end
  end

  // ----------------------------------------
  // watchdog and over-current retry timer
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wd_reg <= 22'h0;
      retry_reg <= 22'h0;
    end else begin
      if (host_alive_pin_n) wd_reg <= 22'h0;
      else if (wd_reg != WD_CYC) wd_reg <= wd_reg + 22'h1;
      retry_reg <= (!(|oc_reg) || retry_tick) ? 22'h0 : retry_reg + 22'h1;
    end
  end

  // ----------------------------------------
  // global registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      auto_reg <= `BPS_OTP_AUTO;
      pinfn_reg <= `BPS_OTP_PINFN;
      irqc_reg <= `BPS_IRQC_RST;
    end else begin
      if (load) begin
        auto_reg <= `BPS_OTP_AUTO;
        pinfn_reg <= `BPS_OTP_PINFN;
      end else if (glob_wr(bus_req, `BPS_G_CFG)) begin
        auto_reg <= bus_req.wdata[`BPS_F_AUTO];
        pinfn_reg <= bus_req.wdata[3:1];
      end
      if (glob_wr(bus_req, `BPS_G_IRQ)) irqc_reg <= bus_req.wdata[4:0];
    end
  end

  // ----------------------------------------
  // per-buck sequencing
  // ----------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_buck
    wire [1:0] bi = 2'(i);
    wire bps_cfg_t c = cfg_reg[i];
    wire w_vlow = buck_wr(bus_req, bi, `BPS_R_VLOW);
    wire [9:0] new_word = {c.vhigh, bus_req.wdata[1:0]};
    wire en_ctl = c.en && (pinfn_reg != `BPS_PINFN_PINS || pin_v[i]);
    wire go_ok = !auto_reg || go_reg[i];
    wire dly_up = ms_reg >= {1'b0, c.ddly};
    bps_out_t o_next;

    always_comb begin
      run_next[i] = 1'b0;
      if (state_reg == BPS_RUN)
        run_next[i] = en_ctl && go_ok && !ot_fault && !oc_reg[i];
      else if (state_reg == BPS_DOWN)
        run_next[i] = out_reg[i].run && !dly_up && !ot_fault;
    end

    always_comb begin
      o_next.run = run_next[i];
      o_next.hiz = oc_reg[i];
      o_next.ramp_dn = !run_next[i] && !vout_low[i] && !oc_reg[i] &&
                       state_reg != BPS_OFF;
      o_next.disch = state_reg == BPS_RUN && master_en && !run_next[i] &&
                     c.dis && vout_low[i] && !oc_reg[i];
      if (wdr_reg[i]) o_next.slew = `BPS_RAMP_DEF;
      else if (!run_next[i]) o_next.slew = c.pdn;
      else if (ss_reg[i] || !out_reg[i].run) o_next.slew = c.pup;
      else if (dn_reg[i]) o_next.slew = c.fall;
      else o_next.slew = c.rise;
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        cfg_reg[i] <= '0;
        vlow_reg[i] <= 2'h0;
      end else if (load) begin
        cfg_reg[i] <= '{3'h3, `BPS_RAMP_DEF, 3'h3, 3'h3, 8'(`BPS_OTP_VWORD >> 2),
                        `BPS_OTP_SDLY, `BPS_OTP_DDLY, `BPS_OTP_EN, `BPS_OTP_DIS};
        vlow_reg[i] <= 2'(`BPS_OTP_VWORD & 10'h3);
      end else if (bus_req.wr && bus_buck && bus_bi == bi) begin
        unique case (bus_off)
          `BPS_R_RAMP_A: begin
            cfg_reg[i].pup <= bus_req.wdata[2:0];
            cfg_reg[i].pdn <= bus_req.wdata[5:3];
          end
          `BPS_R_RAMP_B: begin
            cfg_reg[i].rise <= bus_req.wdata[2:0];
            cfg_reg[i].fall <= bus_req.wdata[5:3];
          end
          `BPS_R_VHIGH: cfg_reg[i].vhigh <= bus_req.wdata;
          `BPS_R_VLOW: vlow_reg[i] <= bus_req.wdata[1:0];
          `BPS_R_SDLY: cfg_reg[i].sdly <= bus_req.wdata[5:0];
          `BPS_R_DDLY: cfg_reg[i].ddly <= bus_req.wdata[5:0];
          `BPS_R_CTRL: begin
            cfg_reg[i].en <= bus_req.wdata[`BPS_F_EN];
            cfg_reg[i].dis <= bus_req.wdata[`BPS_F_DIS];
          end
          default: ;
        endcase
      end
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        tgt_reg[i] <= 10'h0;
        dn_reg[i] <= 1'b0;
      end else if (load || wd_fire) begin
        tgt_reg[i] <= `BPS_OTP_VWORD;
        dn_reg[i] <= `BPS_OTP_VWORD < tgt_reg[i];
      end else if (w_vlow) begin
        tgt_reg[i] <= new_word;
        dn_reg[i] <= new_word < tgt_reg[i];
      end
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        out_reg[i] <= '0;
        go_reg[i] <= 1'b0;
        ss_reg[i] <= 1'b0;
        wdr_reg[i] <= 1'b0;
        oc_reg[i] <= 1'b0;
      end else begin
        out_reg[i] <= o_next;
        go_reg[i] <= state_reg == BPS_RUN &&
                     (go_reg[i] || ms_reg >= {1'b0, c.sdly});
        ss_reg[i] <= (run_next[i] && !out_reg[i].run) ||
                     (ss_reg[i] && run_next[i] && !ramp_done[i]);
        wdr_reg[i] <= wd_fire || (wdr_reg[i] && !ramp_done[i]);
        oc_reg[i] <= oc_det[i] || (oc_reg[i] && !retry_tick);
      end
    end

    assign buck_o[i] = out_reg[i];
    assign target[i] = tgt_reg[i];

    property p_vlow_commit;
      w_vlow && !load && !wd_fire |=> tgt_reg[i] == $past(new_word);
    endproperty
    a_vlow_commit: assert property (p_vlow_commit)
      else $error("low byte write did not commit target");

    property p_vhigh_hold;
      buck_wr(bus_req, bi, `BPS_R_VHIGH) && !load && !wd_fire |=> $stable(tgt_reg[i]);
    endproperty
    a_vhigh_hold: assert property (p_vhigh_hold)
      else $error("high byte write changed target");

    property p_wd_slew;
      wd_fire ##1 !ramp_done[i] |=> out_reg[i].slew == `BPS_RAMP_DEF;
    endproperty
    a_wd_slew: assert property (p_wd_slew)
      else $error("watchdog restore not at default ramp");

    property p_oc_hiz;
      oc_det[i] |=> oc_reg[i] ##1 (out_reg[i].hiz && !out_reg[i].run);
    endproperty
    a_oc_hiz: assert property (p_oc_hiz)
      else $error("over-current did not force high impedance");

    property p_no_disch_down;
      state_reg == BPS_DOWN |=> !out_reg[i].disch;
    endproperty
    a_no_disch_down: assert property (p_no_disch_down)
      else $error("pull-down on during master shutdown");

    property p_manual_start;
      state_reg == BPS_RUN && !auto_reg && en_ctl && !ot_fault && !oc_reg[i]
        && master_en |=> out_reg[i].run;
    endproperty
    a_manual_start: assert property (p_manual_start)
      else $error("manual start delayed");
  end

  // ----------------------------------------
  // interrupt pin
  // ----------------------------------------
  wire [2:0] irq_ev = {|wdr_reg, |oc_reg, ot_fault};
  wire irq_req = |(irq_ev & irqc_reg[4:2]);
  wire irq_lvl = irqc_reg[`BPS_F_IRQ_POL] ? irq_req : !irq_req;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_o_reg <= 1'b0;
      irq_oe_reg <= 1'b1;
    end else begin
      irq_o_reg <= irqc_reg[`BPS_F_IRQ_OD] ? 1'b0 : irq_lvl;
      irq_oe_reg <= irqc_reg[`BPS_F_IRQ_OD] ? !irq_lvl : 1'b1;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  wire bps_cfg_t rc = cfg_reg[bus_bi];
  wire [7:0] b_stat = {3'h0, wdr_reg[bus_bi], ss_reg[bus_bi], out_reg[bus_bi].disch,
                       out_reg[bus_bi].hiz, out_reg[bus_bi].run};
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h0;
    if (bus_buck) begin
      unique case (bus_off)
        `BPS_R_RAMP_A: rd_mux = {2'h0, rc.pdn, rc.pup};
        `BPS_R_RAMP_B: rd_mux = {2'h0, rc.fall, rc.rise};
        `BPS_R_VHIGH: rd_mux = rc.vhigh;
        `BPS_R_VLOW: rd_mux = {6'h0, vlow_reg[bus_bi]};
        `BPS_R_SDLY: rd_mux = {2'h0, rc.sdly};
        `BPS_R_DDLY: rd_mux = {2'h0, rc.ddly};
        `BPS_R_CTRL: rd_mux = {6'h0, rc.dis, rc.en};
        `BPS_R_STAT: rd_mux = b_stat;
        default: rd_mux = 8'h0;
      endcase
    end else if (bus_glob) begin
      unique case (bus_off)
        `BPS_G_CFG: rd_mux = {4'h0, pinfn_reg, auto_reg};
        `BPS_G_IRQ: rd_mux = {3'h0, irqc_reg};
        `BPS_G_STAT: rd_mux = {5'h0, ot_fault, 2'(state_reg)};
        default: rd_mux = 8'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rdata_reg <= 8'h0;
    else rdata_reg <= bus_req.rd ? rd_mux : 8'h0;
  end

  assign rdata = rdata_reg;
  assign bias_on = bias_reg;
  assign irq_o = irq_o_reg;
  assign irq_oe = irq_oe_reg;

  // ----------------------------------------
  // global checks
  // ----------------------------------------
  property p_boot_entry;
    state_reg == BPS_OFF && master_en |=> state_reg == BPS_BOOT && bias_on;
  endproperty
  a_boot_entry: assert property (p_boot_entry)
    else $error("enable rise did not start boot");

  property p_wd_restart;
    host_alive_pin_n |=> wd_reg == 22'h0;
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("watchdog count not restarted");

  property p_ot_off;
    ot_fault |=> (buck_o[0].run == 1'b0 && buck_o[3].run == 1'b0);
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("bucks run during over-temperature");

  c_boot_run: cover property (state_reg == BPS_BOOT ##1 state_reg == BPS_RUN);
  c_wd_fire: cover property (wd_fire);
  c_down_off: cover property (state_reg == BPS_DOWN ##1 state_reg == BPS_OFF);
  c_oc_retry: cover property (oc_reg[0] && retry_tick);

endmodule : bps_sequencer

//--- hdl/bps_regs.svh
`ifndef BPS_REGS_SVH
`define BPS_REGS_SVH

// ----------------------------------------
// address map
// ----------------------------------------
`define BPS_SEL_BUCK 2'h0
`define BPS_SEL_GLOB 2'h1
`define BPS_R_RAMP_A 4'h0
`define BPS_R_RAMP_B 4'h1
`define BPS_R_VHIGH 4'h2
`define BPS_R_VLOW 4'h3
`define BPS_R_SDLY 4'h4
`define BPS_R_DDLY 4'h5
`define BPS_R_CTRL 4'h6
`define BPS_R_STAT 4'h7
`define BPS_G_CFG 4'h0
`define BPS_G_IRQ 4'h1
`define BPS_G_STAT 4'h2

// ----------------------------------------
// field positions
// ----------------------------------------
`define BPS_F_EN 0
`define BPS_F_DIS 1
`define BPS_F_AUTO 0
`define BPS_F_IRQ_POL 0
`define BPS_F_IRQ_OD 1
`define BPS_PINFN_PINS 3'h1

// ----------------------------------------
// stored defaults
// ----------------------------------------
`define BPS_RAMP_DEF 3'h2
`define BPS_OTP_VWORD 10'h1f4
`define BPS_OTP_SDLY 6'h00
`define BPS_OTP_DDLY 6'h01
`define BPS_OTP_AUTO 1'b1
`define BPS_OTP_PINFN 3'h0
`define BPS_OTP_EN 1'b1
`define BPS_OTP_DIS 1'b1
`define BPS_IRQC_RST 5'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define BPS_CLK_NS 5
`define BPS_T_MS_NS 1000000
`define BPS_T_BOOT_NS 1400000
`define BPS_T_WD_NS 10000000
`define BPS_T_RETRY_NS 1000000

`endif

//--- hdl/bps_pkg.sv
package bps_pkg;

  typedef enum logic [1:0] {BPS_OFF, BPS_BOOT, BPS_RUN, BPS_DOWN} bps_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bps_req_t;

  typedef struct packed {
    logic [2:0] pup;
    logic [2:0] pdn;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [7:0] vhigh;
    logic [5:0] sdly;
    logic [5:0] ddly;
    logic en;
    logic dis;
  } bps_cfg_t;

  typedef struct packed {
    logic run;
    logic ramp_dn;
    logic hiz;
    logic disch;
    logic [2:0] slew;
  } bps_out_t;

endpackage : bps_pkg

//--- verification/bps_host_model.sv
`timescale 1ns/1ps
module bps_host_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic en_cmd,
  input wire logic [2:0] pin_cmd,
  input wire logic alive_cmd,
  output logic master_en,
  output logic [2:0] en_pin,
  output logic host_alive_pin_n
);
  // ----------------------------------------
  // host pins
  // ----------------------------------------
  // pins move only after an edge, like a synchronous host port
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      master_en <= 1'b0;
      en_pin <= 3'h7;
      host_alive_pin_n <= 1'b1;
    end else begin
      master_en <= en_cmd;
      en_pin <= pin_cmd;
      host_alive_pin_n <= alive_cmd;
    end
  end
endmodule : bps_host_model

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import bps_pkg::*;
  logic mclk = 1'b0;
  logic rstn;
  bps_req_t bus_req = '0;
  logic [7:0] rdata;
  logic master_en;
  logic host_alive_pin_n;
  logic [2:0] en_pin;
  logic en_cmd = 1'b0;
  logic alive_cmd = 1'b1;
  logic [2:0] pin_cmd = 3'h7;
  logic ot_fault = 1'b0;
  logic [3:0] oc_det = '0;
  logic [3:0] vout_low = '0;
  logic [3:0] ramp_done = '0;
  logic bias_on;
  logic irq_o;
  logic irq_oe;
  bps_out_t [3:0] buck_o;
  logic [3:0][9:0] target;
  logic [7:0] rv;
  int fail_count = 0;
  int checked = 0;

  always #2.5 mclk = ~mclk;

  bps_host_model host (.mclk(mclk), .rstn(rstn), .en_cmd(en_cmd), .pin_cmd(pin_cmd),
    .alive_cmd(alive_cmd), .master_en(master_en), .en_pin(en_pin),
    .host_alive_pin_n(host_alive_pin_n));

  bps_sequencer #(.MS_CYC(22'h14), .BOOT_CYC(22'h1e), .WD_CYC(22'h32), .RETRY_CYC(22'h10)) dut (
    .mclk(mclk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata), .master_en(master_en),
    .en_pin(en_pin), .host_alive_pin_n(host_alive_pin_n), .ot_fault(ot_fault),
    .oc_det(oc_det), .vout_low(vout_low), .ramp_done(ramp_done), .bias_on(bias_on),
    .buck_o(buck_o), .target(target), .irq_o(irq_o), .irq_oe(irq_oe));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    #1;
    d = rdata;
  endtask : rd

  function automatic logic fld(input int f, input int i);
    case (f)
      0: return buck_o[i].run;
      1: return buck_o[i].ramp_dn;
      2: return buck_o[i].hiz;
      3: return buck_o[i].disch;
      default: return bias_on;
    endcase
  endfunction : fld

  // polls one output under a bounded count, then compares it
  task automatic waitf(input string what, input int f, input int i, input logic v,
                       input int max);
    #1;
    for (int k = 0; k < max && fld(f, i) !== v; k++) begin
      cyc(1);
    end
    chk(what, {15'h0, fld(f, i)}, {15'h0, v});
  endtask : waitf

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("bias", {15'h0, bias_on}, 16'h0000);
    chk("target0", {6'h0, target[0]}, 16'h0000);
    chk("irq_oe", {15'h0, irq_oe}, 16'h0001);
    $display("test reset done");
  endtask : t_reset

  task automatic t_boot;
    @(posedge mclk);
    en_cmd <= 1'b1;
    cyc(4);
    chk("bias", {15'h0, bias_on}, 16'h0001);
    cyc(20);
    chk("early run", {15'h0, buck_o[0].run}, 16'h0000);
    waitf("run0", 0, 0, 1'b1, 20);
    for (int i = 0; i < 4; i++) chk("boot word", {6'h0, target[i]}, 16'h01f4);
    chk("pup slew", {13'h0, buck_o[0].slew}, 16'h0003);
    ramp_done <= 4'hf;
    rd(8'h42, rv);
    chk("state", {14'h0, rv[1:0]}, 16'h0002);
    $display("test boot done");
  endtask : t_boot

  task automatic t_vword;
    wr(8'h11, 8'h2c);
    ramp_done[1] <= 1'b0;
    wr(8'h12, 8'h80);
    cyc(2);
    chk("held word", {6'h0, target[1]}, 16'h01f4);
    wr(8'h13, 8'h01);
    chk("commit word", {6'h0, target[1]}, 16'h0201);
    cyc(2);
    chk("rise slew", {13'h0, buck_o[1].slew}, 16'h0004);
    wr(8'h12, 8'h7d);
    wr(8'h13, 8'h00);
    cyc(2);
    chk("fall slew", {13'h0, buck_o[1].slew}, 16'h0005);
    wr(8'h12, 8'h80);
    wr(8'h13, 8'h01);
    ramp_done[1] <= 1'b1;
    rd(8'h12, rv);
    chk("rd high", {8'h0, rv}, 16'h0080);
    rd(8'h08, rv);
    chk("rd unmapped", {8'h0, rv}, 16'h0000);
    $display("test vword done");
  endtask : t_vword

  task automatic t_manual;
    wr(8'h26, 8'h02);
    waitf("bit ramp down", 1, 2, 1'b1, 3);
    chk("others run", {15'h0, buck_o[0].run}, 16'h0001);
    vout_low[2] <= 1'b1;
    waitf("pull down", 3, 2, 1'b1, 3);
    chk("ramp end", {15'h0, buck_o[2].ramp_dn}, 16'h0000);
    wr(8'h24, 8'h05);
    wr(8'h20, 8'h11);
    wr(8'h40, 8'h02);
    vout_low[2] <= 1'b0;
    wr(8'h26, 8'h03);
    waitf("bit start", 0, 2, 1'b1, 3);
    @(posedge mclk);
    pin_cmd[2] <= 1'b0;
    waitf("pin ramp down", 1, 2, 1'b1, 4);
    @(posedge mclk);
    pin_cmd[2] <= 1'b1;
    ramp_done[2] <= 1'b0;
    waitf("pin start", 0, 2, 1'b1, 4);
    chk("pin pup slew", {13'h0, buck_o[2].slew}, 16'h0001);
    ramp_done[2] <= 1'b1;
    cyc(1);
    $display("test manual done");
  endtask : t_manual

  task automatic t_wdog;
    ramp_done <= 4'h0;
    alive_cmd <= 1'b0;
    cyc(40);
    alive_cmd <= 1'b1;
    cyc(2);
    alive_cmd <= 1'b0;
    cyc(40);
    chk("no restore", {6'h0, target[1]}, 16'h0201);
    cyc(20);
    for (int i = 0; i < 4; i++) chk("restore", {6'h0, target[i]}, 16'h01f4);
    chk("wd slew", {13'h0, buck_o[1].slew}, 16'h0002);
    alive_cmd <= 1'b1;
    ramp_done <= 4'hf;
    cyc(2);
    $display("test wdog done");
  endtask : t_wdog

  task automatic t_fault;
    wr(8'h41, 8'h05);
    ot_fault <= 1'b1;
    waitf("ot off", 0, 0, 1'b0, 4);
    chk("ot off3", {15'h0, buck_o[3].run}, 16'h0000);
    cyc(1);
    chk("irq high", {14'h0, irq_o, irq_oe}, 16'h0003);
    wr(8'h41, 8'h06);
    cyc(2);
    chk("irq od", {14'h0, irq_o, irq_oe}, 16'h0001);
    ot_fault <= 1'b0;
    waitf("ot back", 0, 0, 1'b1, 6);
    cyc(2);
    chk("irq idle", {15'h0, irq_oe}, 16'h0000);
    oc_det[3] <= 1'b1;
    @(posedge mclk);
    oc_det[3] <= 1'b0;
    waitf("oc hiz", 2, 3, 1'b1, 4);
    chk("oc off", {15'h0, buck_o[3].run}, 16'h0000);
    waitf("oc retry", 0, 3, 1'b1, 24);
    $display("test fault done");
  endtask : t_fault

  task automatic t_down;
    ramp_done <= 4'h0;
    en_cmd <= 1'b0;
    cyc(12);
    chk("delay held", {15'h0, buck_o[0].ramp_dn}, 16'h0000);
    waitf("auto ramp down", 1, 0, 1'b1, 16);
    chk("pdn slew", {13'h0, buck_o[0].slew}, 16'h0002);
    vout_low <= 4'h1;
    cyc(3);
    chk("no pull down", {15'h0, buck_o[0].disch}, 16'h0000);
    vout_low <= 4'hf;
    waitf("bias off", 4, 0, 1'b0, 10);
    $display("test down done");
  endtask : t_down

  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    cyc(1);
    t_reset;
    t_boot;
    t_vword;
    t_manual;
    t_wdog;
    t_fault;
    t_down;
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("ERROR watchdog expected finish seen hang");
    stop_test;
  end
endmodule : tb_top
